// File: common/ssrc_pkg.sv
package ssrc_pkg;

    // frame and bus geometry
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned BUS_W     = 32;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_RXDATA   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MODCTL   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_DIVISOR  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ST   = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;

    // serial status bits
    localparam int unsigned ST_RXFULL  = 0;
    localparam int unsigned ST_OVERRUN = 1;
    localparam int unsigned ST_NOCONT  = 2;

    // module control: standby, transmit pin select, reserved ones
    localparam int unsigned MC_STANDBY   = 0;
    localparam int unsigned MC_TXSEL     = 1;
    localparam int unsigned MC_W         = 2;
    localparam logic [7:0]  MC_RSVD_ONES = 8'hfc;
    localparam logic [MC_W-1:0] MC_RST   = 2'h0;

    // receive control
    localparam int unsigned CTRL_RXEN   = 0;
    localparam int unsigned CTRL_INTCLK = 1;
    localparam int unsigned CTRL_W      = 2;
    localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;

    // bit-rate divisor: count in low byte, shift select above
    localparam int unsigned DIV_N_LSB  = 0;
    localparam int unsigned DIV_N_W    = 8;
    localparam int unsigned DIV_SH_LSB = 8;
    localparam int unsigned DIV_SH_W   = 2;
    localparam int unsigned DIV_W      = 10;
    localparam logic [DIV_W-1:0] DIV_RST = 10'h0ff;
    localparam int unsigned HALF_W     = 15;

    // interrupt status and mask bits
    localparam int unsigned IRQ_RXDONE  = 0;
    localparam int unsigned IRQ_OVERRUN = 1;
    localparam int unsigned IRQ_W       = 2;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

    // link lines after synchronisation
    typedef struct packed {
        logic sck;
        logic rxd;
    } ssrc_link_type;

    // one completed frame
    typedef struct packed {
        logic [DATA_BITS-1:0] data;
        logic                 done;
    } ssrc_frame_type;

    typedef enum {RX_OFF, RX_SHIFT} ssrc_rx_state_type;

endpackage : ssrc_pkg

// File: design/ssrc_shift.sv
`timescale 1ns/1ps
module ssrc_shift (
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    nrst,
    // receive enable
    input  wire logic                    enable,
    // synchronised link lines
    input  wire ssrc_pkg::ssrc_link_type link,
    // completed frame
    output ssrc_pkg::ssrc_frame_type     frame
);

    localparam int unsigned DB    = ssrc_pkg::DATA_BITS;
    localparam int unsigned CNT_W = $clog2(DB);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(DB - 1);

    ssrc_pkg::ssrc_rx_state_type state_q;
    ssrc_pkg::ssrc_rx_state_type state_d;
    logic                        sck_prev_q;
    logic [CNT_W-1:0]            cnt_q;
    logic [DB-1:0]               shreg_q;
    ssrc_pkg::ssrc_frame_type    frame_q;

    // edge find and shift decode
    wire          sck_rise  = link.sck & ~sck_prev_q;
    wire          shift_now = (state_q == ssrc_pkg::RX_SHIFT) & enable
                              & sck_rise;
    wire          last_bit  = shift_now & (cnt_q == LAST);
    wire [DB-1:0] shreg_nx  = {link.rxd, shreg_q[DB-1:1]};

    // receiver on or off
    always_comb begin
        case (state_q)
            ssrc_pkg::RX_OFF:   state_d = enable ? ssrc_pkg::RX_SHIFT
                                                 : ssrc_pkg::RX_OFF;
            ssrc_pkg::RX_SHIFT: state_d = enable ? ssrc_pkg::RX_SHIFT
                                                 : ssrc_pkg::RX_OFF;
            default:            state_d = ssrc_pkg::RX_OFF;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_q    <= ssrc_pkg::RX_OFF;
            sck_prev_q <= 1'b1;
        end else begin
            state_q    <= state_d;
            sck_prev_q <= link.sck;
        end
    end

    // bit counter, always eight per frame
    always_ff @(posedge mclk) begin
        if (!nrst || state_q != ssrc_pkg::RX_SHIFT) begin
            cnt_q <= '0;
        end else if (shift_now) begin
            cnt_q <= last_bit ? '0 : cnt_q + 1'b1;
        end
    end

    // lsb first shift on rising clock edge
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            shreg_q <= '0;
        end else if (shift_now) begin
            shreg_q <= shreg_nx;
        end
    end

    // frame hand-off, done is a one-cycle pulse
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            frame_q <= '0;
        end else begin
            frame_q.done <= last_bit;
            if (last_bit) begin
                frame_q.data <= shreg_nx;
            end
        end
    end

    assign frame = frame_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence eighth_edge_s;
        shift_now && cnt_q == LAST;
    endsequence

    frame_eight_a: assert property (
        eighth_edge_s |=> frame_q.done && frame_q.data[DB-1] == $past(link.rxd))
        else $error("frame not closed on eighth bit");
    done_pulse_a: assert property (
        frame_q.done |=> !frame_q.done)
        else $error("frame done longer than one cycle");

endmodule : ssrc_shift

// File: design/ssrc_top.sv
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module ssrc_top (
    // clock and reset
    input  wire logic                           mclk,
    input  wire logic                           nrst,
    // apb slave
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [ssrc_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [ssrc_pkg::BUS_W-1:0]     pwdata,
    output logic      [ssrc_pkg::BUS_W-1:0]     prdata,
    output logic                                pready,
    output logic                                pslverr,
    // serial link pins
    input  wire logic                           sck_pin_i,
    input  wire logic                           rxd_pin_i,
    output logic                                sck_pin_o,
    output logic                                sck_pin_oe_n,
    // shared transmit pin
    input  wire logic                           chan_txd,
    input  wire logic                           gpio_out,
    input  wire logic                           gpio_oe_n,
    output logic                                txd_pin_o,
    output logic                                txd_pin_oe_n,
    // status
    output logic                                unit_standby,
    output logic                                irq
);

    localparam int unsigned DB = ssrc_pkg::DATA_BITS;
    localparam int unsigned HW = ssrc_pkg::HALF_W;
    localparam int unsigned IW = ssrc_pkg::IRQ_W;

    ssrc_pkg::ssrc_link_type              meta_q;
    ssrc_pkg::ssrc_link_type              sync_q;
    ssrc_pkg::ssrc_link_type              rx_link;
    ssrc_pkg::ssrc_frame_type             frame;
    logic [ssrc_pkg::MC_W-1:0]            modctl_q;
    logic [ssrc_pkg::CTRL_W-1:0]          ctrl_q;
    logic [ssrc_pkg::DIV_W-1:0]           div_q;
    logic                                 rx_full_q;
    logic                                 rx_full_d;
    logic                                 overrun_q;
    logic                                 overrun_d;
    logic [DB-1:0]                        rx_data_q;
    logic [IW-1:0]                        irq_st_q;
    logic [IW-1:0]                        irq_st_d;
    logic [IW-1:0]                        irq_mask_q;
    logic [IW-1:0]                        irq_ev;
    logic [ssrc_pkg::BUS_W-1:0]           prdata_q;
    logic [ssrc_pkg::BUS_W-1:0]           status_word;
    logic                                 resp_q;
    logic                                 slverr_q;
    logic [HW-1:0]                        div_cnt_q;
    logic                                 sck_int_q;
    logic                                 pin_o_q;
    logic                                 pin_oe_n_q;

    // two-stage synchroniser for the link pins
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= '{sck: sck_pin_i, rxd: rxd_pin_i};
            sync_q <= meta_q;
        end
    end

    // apb phase decode
    wire setup  = psel & ~penable;
    wire access = psel & penable & resp_q;
    wire wr     = access & pwrite;
    wire rd     = access & ~pwrite;

    // address decode
    wire sel_status   = (paddr == ssrc_pkg::OFS_STATUS);
    wire sel_rxdata   = (paddr == ssrc_pkg::OFS_RXDATA);
    wire sel_modctl   = (paddr == ssrc_pkg::OFS_MODCTL);
    wire sel_ctrl     = (paddr == ssrc_pkg::OFS_CTRL);
    wire sel_divisor  = (paddr == ssrc_pkg::OFS_DIVISOR);
    wire sel_irq_st   = (paddr == ssrc_pkg::OFS_IRQ_ST);
    wire sel_irq_mask = (paddr == ssrc_pkg::OFS_IRQ_MASK);
    wire mapped       = sel_status | sel_rxdata | sel_modctl | sel_ctrl
                        | sel_divisor | sel_irq_st | sel_irq_mask;

    // control fields
    wire standby   = modctl_q[ssrc_pkg::MC_STANDBY];
    wire tx_sel    = modctl_q[ssrc_pkg::MC_TXSEL];
    wire int_clk   = ctrl_q[ssrc_pkg::CTRL_INTCLK];
    wire rx_enable = ctrl_q[ssrc_pkg::CTRL_RXEN] & ~standby
                     & ~overrun_q;
    wire div_run   = int_clk & ~standby;

    // bit-rate divisor fields and half period
    wire [ssrc_pkg::DIV_N_W-1:0]  div_n  =
        div_q[ssrc_pkg::DIV_N_LSB +: ssrc_pkg::DIV_N_W];
    wire [ssrc_pkg::DIV_SH_W-1:0] div_sh =
        div_q[ssrc_pkg::DIV_SH_LSB +: ssrc_pkg::DIV_SH_W];
    wire [HW-1:0] half_len = (HW'(div_n) + HW'(1)) << {div_sh, 1'b0};
    wire [HW-1:0] half_m1  = half_len - HW'(1);
    wire          div_tick = div_run & (div_cnt_q >= half_m1);
    wire          no_cont  = (div_n == '0) & (div_sh == '0);

    // internal serial clock, idles high
    always_ff @(posedge mclk) begin
        if (!nrst || !div_run) begin
            div_cnt_q <= '0;
            sck_int_q <= 1'b1;
        end else if (div_tick) begin
            div_cnt_q <= '0;
            sck_int_q <= ~sck_int_q;
        end else begin
            div_cnt_q <= div_cnt_q + 1'b1;
        end
    end

    // receiver clock source select
    assign rx_link.sck = int_clk ? sck_int_q : sync_q.sck;
    assign rx_link.rxd = sync_q.rxd;

    ssrc_shift u_shift (
        .mclk   (mclk),
        .nrst   (nrst),
        .enable (rx_enable),
        .link   (rx_link),
        .frame  (frame)
    );

    // receive events and flag terms
    wire rxdata_rd  = rd & sel_rxdata;
    wire accept     = frame.done & (~rx_full_q | rxdata_rd);
    wire overrun_ev = frame.done & rx_full_q & ~rxdata_rd;
    wire ovr_clr    = wr & sel_status & ~pwdata[ssrc_pkg::ST_OVERRUN];
    wire irq_clr_wr = wr & sel_irq_st;

    // set wins over clear on every flag
    assign rx_full_d = accept | (rx_full_q & ~rxdata_rd);
    assign overrun_d = overrun_ev | (overrun_q & ~ovr_clr);

    // interrupt events, write one to clear
    always_comb begin
        irq_ev = '0;
        irq_ev[ssrc_pkg::IRQ_RXDONE]  = accept;
        irq_ev[ssrc_pkg::IRQ_OVERRUN] = overrun_ev;
        irq_st_d = irq_ev
                   | (irq_st_q & ~(irq_clr_wr ? pwdata[IW-1:0] : '0));
    end

    // receive flags and data
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rx_full_q <= 1'b0;
            overrun_q <= 1'b0;
            irq_st_q  <= '0;
        end else begin
            rx_full_q <= rx_full_d;
            overrun_q <= overrun_d;
            irq_st_q  <= irq_st_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rx_data_q <= '0;
        end else if (accept) begin
            rx_data_q <= frame.data;
        end
    end

    // software written registers
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            modctl_q   <= ssrc_pkg::MC_RST;
            ctrl_q     <= ssrc_pkg::CTRL_RST;
            div_q      <= ssrc_pkg::DIV_RST;
            irq_mask_q <= ssrc_pkg::IRQ_MASK_RST;
        end else begin
            if (wr && sel_modctl) modctl_q <= pwdata[ssrc_pkg::MC_W-1:0];
            if (wr && sel_ctrl) ctrl_q <= pwdata[ssrc_pkg::CTRL_W-1:0];
            if (wr && sel_divisor) div_q <= pwdata[ssrc_pkg::DIV_W-1:0];
            if (wr && sel_irq_mask) irq_mask_q <= pwdata[IW-1:0];
        end
    end

    // status word: full, overrun and rate note only
    always_comb begin
        status_word = '0;
        status_word[ssrc_pkg::ST_RXFULL]  = rx_full_q;
        status_word[ssrc_pkg::ST_OVERRUN] = overrun_q;
        status_word[ssrc_pkg::ST_NOCONT]  = no_cont;
    end

    // read selection
    wire [7:0] modctl_rd = ssrc_pkg::MC_RSVD_ONES
                           | {6'h00, modctl_q};
    wire [ssrc_pkg::BUS_W-1:0] rd_word =
        sel_status   ? status_word :
        sel_rxdata   ? {24'h000000, rx_data_q} :
        sel_modctl   ? {24'h000000, modctl_rd} :
        sel_ctrl     ? {30'h00000000, ctrl_q} :
        sel_divisor  ? {22'h000000, div_q} :
        sel_irq_st   ? {30'h00000000, irq_st_q} :
        sel_irq_mask ? {30'h00000000, irq_mask_q} : '0;

    // read data captured in setup, answer in first access cycle
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            resp_q   <= 1'b0;
            slverr_q <= 1'b0;
            prdata_q <= '0;
        end else if (setup) begin
            resp_q   <= 1'b1;
            slverr_q <= ~mapped;
            prdata_q <= pwrite ? '0 : rd_word;
        end else if (access) begin
            resp_q   <= 1'b0;
        end
    end

    // shared pin: port or transmit output
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pin_o_q    <= 1'b1;
            pin_oe_n_q <= 1'b1;
        end else begin
            pin_o_q    <= tx_sel ? chan_txd : gpio_out;
            pin_oe_n_q <= tx_sel ? 1'b0 : gpio_oe_n;
        end
    end

    // outputs
    assign prdata       = prdata_q;
    assign pready       = access;
    assign pslverr      = access & slverr_q;
    assign sck_pin_o    = sck_int_q;
    assign sck_pin_oe_n = ~div_run;
    assign txd_pin_o    = pin_o_q;
    assign txd_pin_oe_n = pin_oe_n_q;
    assign unit_standby = standby;
    assign irq          = |(irq_st_q & irq_mask_q);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence data_read_s;
        rxdata_rd && !frame.done;
    endsequence
    sequence late_frame_s;
        frame.done && rx_full_q && !rxdata_rd;
    endsequence
    sequence status_read_s;
        setup && sel_status && !pwrite;
    endsequence

    rxfull_clear_a: assert property (
        data_read_s |=> !rx_full_q)
        else $error("receive full not cleared by data read");
    rxfull_setwin_a: assert property (
        frame.done && rxdata_rd |=> rx_full_q && !overrun_q)
        else $error("frame lost while data was read");
    overrun_set_a: assert property (
        late_frame_s |=> overrun_q && rx_data_q == $past(rx_data_q))
        else $error("overrun not raised or data overwritten");
    overrun_stop_a: assert property (
        overrun_q [*2] |-> !frame.done && !accept)
        else $error("reception resumed during overrun");
    overrun_clear_a: assert property (
        ovr_clr && !overrun_ev |=> !overrun_q)
        else $error("overrun not cleared by write of zero");
    status_only_a: assert property (
        status_read_s |=> prdata_q[ssrc_pkg::BUS_W-1:ssrc_pkg::ST_NOCONT+1]
                          == '0)
        else $error("unexpected status error bit");
    nocont_flag_a: assert property (
        status_read_s and no_cont |=> prdata_q[ssrc_pkg::ST_NOCONT])
        else $error("no continuous flag missing");
    rsvd_ones_a: assert property (
        setup && sel_modctl && !pwrite
        |=> prdata_q[7:2] == ssrc_pkg::MC_RSVD_ONES[7:2]
            && prdata_q[1:0] == $past(modctl_q))
        else $error("module control readback wrong");
    txd_route_a: assert property (
        tx_sel |=> !txd_pin_oe_n && txd_pin_o == $past(chan_txd))
        else $error("transmit output not routed to pin");
    standby_halt_a: assert property (
        standby [*2] |-> !rx_enable && sck_pin_oe_n && sck_pin_o)
        else $error("channel active in standby");
    irq_raise_a: assert property (
        accept && irq_mask_q[ssrc_pkg::IRQ_RXDONE] |=> irq)
        else $error("unmasked receive event gave no interrupt");

endmodule : ssrc_top

// File: verif/ssrc_link_src.sv
`timescale 1ns/1ps
module ssrc_link_src (
    // clock that line changes are aligned to
    input  logic mclk,
    // serial link lines toward the receiver
    output logic sck,
    output logic rxd
);

    // clock idles high between frames, data line starts high
    initial begin
        sck = 1'b1;
        rxd = 1'b1;
    end

    // one frame: eight bits lsb first, data moved on the falling edge,
    // each half period four mclk cycles, a 160 ns link period
    task send(input logic [7:0] b);
        @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            sck <= 1'b0;
            rxd <= b[i];
            repeat (4) @(posedge mclk);
            sck <= 1'b1;
            repeat (4) @(posedge mclk);
        end
        // line released: show the inverse of the last bit, clock stays high
        rxd <= ~b[7];
    endtask : send

endmodule : ssrc_link_src

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;

    // clock, reset, apb and pin signals
    logic        mclk = 1'b0;
    logic        nrst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sck_pin_o;
    logic        sck_pin_oe_n;
    logic        chan_txd;
    logic        gpio_out;
    logic        gpio_oe_n;
    logic        txd_pin_o;
    logic        txd_pin_oe_n;
    logic        unit_standby;
    logic        irq;
    logic        src_sck;
    logic        src_rxd;
    wire         sck_w;
    logic [31:0] d;
    logic        e;
    int          bad_count  = 0;
    int          n_compared = 0;

    // clock and shared serial clock wire
    always #10 mclk = ~mclk;
    assign sck_w = sck_pin_oe_n ? src_sck : sck_pin_o;

    ssrc_top dut_u (
        .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sck_pin_i(sck_w), .rxd_pin_i(src_rxd), .sck_pin_o(sck_pin_o),
        .sck_pin_oe_n(sck_pin_oe_n), .chan_txd(chan_txd),
        .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
        .txd_pin_o(txd_pin_o), .txd_pin_oe_n(txd_pin_oe_n),
        .unit_standby(unit_standby), .irq(irq)
    );

    ssrc_link_src src_u (
        .mclk(mclk),
        .sck(src_sck),
        .rxd(src_rxd)
    );

    // counts, verdict and end of run
    task test_done();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    // value compare
    task chk(input logic [31:0] got, input logic [31:0] exp,
             input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask : chk

    // one apb transfer, held until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] rd, output logic err);
        int n;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge mclk);
        end
        if (pready !== 1'b1) begin
            bad_count++;
            $display("MISMATCH at %0t: no pready", $time);
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // register write and checked read
    task wr(input logic [7:0] a, input logic [31:0] v);
        apb(1'b1, a, v, d, e);
        chk({31'h0, e}, 32'h0, "write error flag");
    endtask : wr

    task rd_chk(input logic [7:0] a, input logic [31:0] exp,
                input string what);
        apb(1'b0, a, 32'h0, d, e);
        chk(d, exp, what);
    endtask : rd_chk

    // poll a status bit with a bounded number of reads
    task wait_st(input int b);
        int n;
        n = 0;
        d = 32'h0;
        while (d[b] !== 1'b1 && n < 40) begin
            apb(1'b0, ssrc_pkg::OFS_STATUS, 32'h0, d, e);
            n++;
        end
        if (d[b] !== 1'b1) begin
            bad_count++;
            $display("MISMATCH at %0t: status bit never set", $time);
            test_done();
        end
    endtask : wait_st

    task idle(input int n);
        repeat (n) @(posedge mclk);
    endtask : idle

    // register offsets and reset values
    logic [7:0]  offs [7] = '{ssrc_pkg::OFS_STATUS, ssrc_pkg::OFS_RXDATA,
        ssrc_pkg::OFS_MODCTL, ssrc_pkg::OFS_CTRL, ssrc_pkg::OFS_DIVISOR,
        ssrc_pkg::OFS_IRQ_ST, ssrc_pkg::OFS_IRQ_MASK};
    logic [31:0] rstv [7] = '{32'h0, 32'h0, 32'hfc, 32'h0, 32'h0ff,
        32'h0, 32'h0};

    // main sequence
    initial begin
        nrst      = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h0;
        chan_txd  = 1'b0;
        gpio_out  = 1'b1;
        gpio_oe_n = 1'b1;
        idle(3);
        nrst <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd_chk(offs[i], rstv[i], "reset value");
        end
        apb(1'b0, 8'h1c, 32'h0, d, e);
        chk({31'h0, e}, 32'h1, "unmapped error");
        chk(d, 32'h0, "unmapped data");
        wr(ssrc_pkg::OFS_DIVISOR, 32'h0);
        rd_chk(ssrc_pkg::OFS_STATUS, 32'h4, "no continuous");
        wr(ssrc_pkg::OFS_DIVISOR, 32'h0ff);
        rd_chk(ssrc_pkg::OFS_STATUS, 32'h0, "continuous ok");
        idle(2);
        chk({31'h0, txd_pin_o}, 32'h1, "pin as port");
        chk({31'h0, txd_pin_oe_n}, 32'h1, "port enable");
        gpio_out  <= 1'b0;
        gpio_oe_n <= 1'b0;
        idle(2);
        chk({31'h0, txd_pin_o}, 32'h0, "port data follows");
        chk({31'h0, txd_pin_oe_n}, 32'h0, "port enable follows");
        gpio_out  <= 1'b1;
        gpio_oe_n <= 1'b1;
        wr(ssrc_pkg::OFS_MODCTL, 32'h2);
        idle(2);
        chk({31'h0, txd_pin_o}, 32'h0, "pin as transmit");
        chk({31'h0, txd_pin_oe_n}, 32'h0, "transmit enable");
        chan_txd <= 1'b1;
        idle(2);
        chk({31'h0, txd_pin_o}, 32'h1, "transmit follows");
        rd_chk(ssrc_pkg::OFS_MODCTL, 32'hfe, "modctl readback");
        // standby: a frame must not be taken
        wr(ssrc_pkg::OFS_MODCTL, 32'h1);
        idle(1);
        chk({31'h0, unit_standby}, 32'h1, "standby pin");
        rd_chk(ssrc_pkg::OFS_MODCTL, 32'hfd, "modctl standby");
        wr(ssrc_pkg::OFS_CTRL, 32'h1);
        wr(ssrc_pkg::OFS_IRQ_MASK, 32'h3);
        src_u.send(8'h96);
        idle(8);
        rd_chk(ssrc_pkg::OFS_STATUS, 32'h0, "standby no rx");
        wr(ssrc_pkg::OFS_MODCTL, 32'h0);
        idle(1);
        chk({31'h0, unit_standby}, 32'h0, "standby off");
        // plain frame with interrupt
        src_u.send(8'ha5);
        wait_st(ssrc_pkg::ST_RXFULL);
        rd_chk(ssrc_pkg::OFS_STATUS, 32'h1, "status full");
        chk({31'h0, irq}, 32'h1, "irq raised");
        rd_chk(ssrc_pkg::OFS_IRQ_ST, 32'h1, "irq status");
        rd_chk(ssrc_pkg::OFS_RXDATA, 32'ha5, "rx byte");
        rd_chk(ssrc_pkg::OFS_STATUS, 32'h0, "full cleared");
        wr(ssrc_pkg::OFS_IRQ_ST, 32'h1);
        idle(1);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        // overrun with interrupt masked
        wr(ssrc_pkg::OFS_IRQ_MASK, 32'h0);
        src_u.send(8'h3c);
        wait_st(ssrc_pkg::ST_RXFULL);
        chk({31'h0, irq}, 32'h0, "irq masked");
        src_u.send(8'hc3);
        wait_st(ssrc_pkg::ST_OVERRUN);
        rd_chk(ssrc_pkg::OFS_STATUS, 32'h3, "overrun set");
        rd_chk(ssrc_pkg::OFS_RXDATA, 32'h3c, "old byte kept");
        rd_chk(ssrc_pkg::OFS_IRQ_ST, 32'h3, "irq both");
        src_u.send(8'h11);
        idle(8);
        rd_chk(ssrc_pkg::OFS_STATUS, 32'h2, "held off");
        wr(ssrc_pkg::OFS_STATUS, 32'h0);
        rd_chk(ssrc_pkg::OFS_STATUS, 32'h0, "overrun clear");
        src_u.send(8'h5a);
        wait_st(ssrc_pkg::ST_RXFULL);
        rd_chk(ssrc_pkg::OFS_RXDATA, 32'h5a, "resumed byte");
        wr(ssrc_pkg::OFS_IRQ_MASK, 32'h3);
        idle(1);
        chk({31'h0, irq}, 32'h1, "irq unmasked");
        wr(ssrc_pkg::OFS_IRQ_ST, 32'h3);
        idle(1);
        chk({31'h0, irq}, 32'h0, "irq all clear");
        rd_chk(ssrc_pkg::OFS_IRQ_ST, 32'h0, "irq status clear");
        // internal clock: line held high, so the frame is all ones
        wr(ssrc_pkg::OFS_DIVISOR, 32'h1);
        wr(ssrc_pkg::OFS_CTRL, 32'h3);
        idle(1);
        chk({31'h0, sck_pin_oe_n}, 32'h0, "internal clock driven");
        wait_st(ssrc_pkg::ST_RXFULL);
        rd_chk(ssrc_pkg::OFS_RXDATA, 32'hff, "internal clock byte");
        wr(ssrc_pkg::OFS_CTRL, 32'h0);
        idle(2);
        chk({31'h0, sck_pin_oe_n}, 32'h1, "clock pin released");
        chk({31'h0, sck_pin_o}, 32'h1, "clock idles high");
        test_done();
    end

endmodule : tb
